// >>> logic/analog_powerdown_override_bank.sv
// analog power-down override register bank with power-state selection
`timescale 1ns/1ns
`include "pwr_ovr_params.svh"
module analog_powerdown_override_bank (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire pwr_ovr_pkg::reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire pwr_ovr_pkg::pwr_vec_t auto_pwr_up,
  input wire logic [5:0] left_line_ovr,
  input wire logic [4:0] right_state_a,
  input wire logic [7:0] right_state_b,
  output pwr_ovr_pkg::pwr_vec_t pwr_up
);
  import pwr_ovr_pkg::*;

  // ------------------------------------------------------------------
  // register storage
  // ------------------------------------------------------------------
  logic [7:0] left_power_override_b;
  logic [7:0] left_power_state_a;
  logic [7:0] left_power_state_b;
  logic [7:0] right_power_override_a;
  logic [7:0] right_power_override_b;
  logic [7:0] next_rdata;

  // reserved bits are not stored, so they can never steer a block
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      left_power_override_b <= `PWR_RESET_VALUE;
      left_power_state_a <= `PWR_RESET_VALUE;
      left_power_state_b <= `PWR_RESET_VALUE;
      right_power_override_a <= `PWR_RESET_VALUE;
      right_power_override_b <= `PWR_RESET_VALUE;
    end else if (reg_req.we) begin
      if (reg_req.addr == `PWR_ADDR_LEFT_OVR_B) begin
        left_power_override_b <= reg_req.wdata & `PWR_MASK_LEFT_OVR_B;
      end else if (reg_req.addr == `PWR_ADDR_LEFT_STATE_A) begin
        left_power_state_a <= reg_req.wdata & `PWR_MASK_LEFT_STATE_A;
      end else if (reg_req.addr == `PWR_ADDR_LEFT_STATE_B) begin
        left_power_state_b <= reg_req.wdata & `PWR_MASK_LEFT_STATE_B;
      end else if (reg_req.addr == `PWR_ADDR_RIGHT_OVR_A) begin
        right_power_override_a <= reg_req.wdata & `PWR_MASK_RIGHT_OVR_A;
      end else if (reg_req.addr == `PWR_ADDR_RIGHT_OVR_B) begin
        right_power_override_b <= reg_req.wdata & `PWR_MASK_RIGHT_OVR_B;
      end
    end
  end

  // ------------------------------------------------------------------
  // read decode
  // ------------------------------------------------------------------
  always_comb begin
    if (reg_req.addr == `PWR_ADDR_LEFT_OVR_B) begin
      next_rdata = left_power_override_b;
    end else if (reg_req.addr == `PWR_ADDR_LEFT_STATE_A) begin
      next_rdata = left_power_state_a;
    end else if (reg_req.addr == `PWR_ADDR_LEFT_STATE_B) begin
      next_rdata = left_power_state_b;
    end else if (reg_req.addr == `PWR_ADDR_RIGHT_OVR_A) begin
      next_rdata = right_power_override_a;
    end else if (reg_req.addr == `PWR_ADDR_RIGHT_OVR_B) begin
      next_rdata = right_power_override_b;
    end else begin
      next_rdata = `PWR_READ_ZERO;
    end
  end

  // read data registered; a read in the same cycle as a write sees the old value
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      reg_rdata <= `PWR_READ_ZERO;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_req.re;
      if (reg_req.re) begin
        reg_rdata <= next_rdata;
      end
    end
  end

  // ------------------------------------------------------------------
  // power-state selection per group
  // ------------------------------------------------------------------
  pwr_select #(.W(8), .USED(`PWR_MASK_LEFT_OVR_B)) u_left_b (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .ovr(left_power_override_b),
    .state(left_power_state_b),
    .auto_up(auto_pwr_up.left_b),
    .pwr_up(pwr_up.left_b)
  );

  // overrides for this group live in a neighbouring register outside the bank
  pwr_select #(.W(6), .USED(`PWR_MASK_LEFT_LINE)) u_left_a (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .ovr(left_line_ovr),
    .state(left_power_state_a[5:0]),
    .auto_up(auto_pwr_up.left_a),
    .pwr_up(pwr_up.left_a)
  );

  // forced states for the right channel come from registers beyond the bank
  pwr_select #(.W(5), .USED(`PWR_MASK_RIGHT_STATE_A)) u_right_a (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .ovr(right_power_override_a[4:0]),
    .state(right_state_a),
    .auto_up(auto_pwr_up.right_a),
    .pwr_up(pwr_up.right_a)
  );

  pwr_select #(.W(8), .USED(`PWR_MASK_RIGHT_OVR_B)) u_right_b (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .ovr(right_power_override_b),
    .state(right_state_b),
    .auto_up(auto_pwr_up.right_b),
    .pwr_up(pwr_up.right_b)
  );

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  AST_WRITE_LEFT_OVR_B: assert property (@(posedge clk_sys) disable iff (sys_rst)
    reg_req.we && reg_req.addr == `PWR_ADDR_LEFT_OVR_B |=> left_power_override_b == $past(reg_req.wdata))
    else $error("left override write not stored");

  AST_WRITE_LEFT_STATE_A: assert property (@(posedge clk_sys) disable iff (sys_rst)
    reg_req.we && reg_req.addr == `PWR_ADDR_LEFT_STATE_A
    |=> left_power_state_a == ($past(reg_req.wdata) & `PWR_MASK_LEFT_STATE_A))
    else $error("left state a write wrong or reserved bits kept");

  AST_WRITE_LEFT_STATE_B: assert property (@(posedge clk_sys) disable iff (sys_rst)
    reg_req.we && reg_req.addr == `PWR_ADDR_LEFT_STATE_B |=> left_power_state_b == $past(reg_req.wdata))
    else $error("left state b write not stored");

  AST_WRITE_RIGHT_OVR_A: assert property (@(posedge clk_sys) disable iff (sys_rst)
    reg_req.we && reg_req.addr == `PWR_ADDR_RIGHT_OVR_A
    |=> right_power_override_a == ($past(reg_req.wdata) & `PWR_MASK_RIGHT_OVR_A))
    else $error("right override a write wrong");

  AST_RIGHT_RSVD_ZERO: assert property (@(posedge clk_sys) disable iff (sys_rst)
    reg_req.we && reg_req.addr == `PWR_ADDR_RIGHT_OVR_B
    |=> right_power_override_b[`PWR_BIT_RIGHT_RSVD] == 1'b0
        && right_power_override_b == ($past(reg_req.wdata) & `PWR_MASK_RIGHT_OVR_B))
    else $error("right override b write wrong");

  AST_RESET_CLEARS: assert property (@(posedge clk_sys)
    sys_rst |=> left_power_override_b == 8'h00 && left_power_state_a == 8'h00 && left_power_state_b == 8'h00
        && right_power_override_a == 8'h00 && right_power_override_b == 8'h00 && pwr_up == '0)
    else $error("reset did not clear bank");

  AST_READBACK: assert property (@(posedge clk_sys) disable iff (sys_rst)
    reg_req.re && !reg_req.we && reg_req.addr == `PWR_ADDR_LEFT_STATE_B
    |=> reg_rvalid && reg_rdata == left_power_state_b)
    else $error("readback mismatch");

  AST_UNMAPPED_ZERO: assert property (@(posedge clk_sys) disable iff (sys_rst)
    reg_req.re && (reg_req.addr < `PWR_ADDR_LEFT_OVR_B || reg_req.addr > `PWR_ADDR_RIGHT_OVR_B)
    |=> reg_rvalid && reg_rdata == 8'h00)
    else $error("unmapped read not zero");

  AST_FORCED_GAIN: assert property (@(posedge clk_sys) disable iff (sys_rst)
    left_power_override_b[`PWR_BIT_LEFT_GAIN]
    |=> pwr_up.left_b[`PWR_BIT_LEFT_GAIN] == $past(left_power_state_b[`PWR_BIT_LEFT_GAIN]))
    else $error("forced gain state not applied");

  AST_AUTO_PUMP: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !left_power_override_b[`PWR_BIT_CHARGE_PUMP]
    |=> pwr_up.left_b[`PWR_BIT_CHARGE_PUMP] == $past(auto_pwr_up.left_b[`PWR_BIT_CHARGE_PUMP]))
    else $error("charge pump not on automatic control");

  AST_FORCED_RIGHT_DAC: assert property (@(posedge clk_sys) disable iff (sys_rst)
    right_power_override_a[`PWR_BIT_RIGHT_DAC]
    |=> pwr_up.right_a[`PWR_BIT_RIGHT_DAC] == $past(right_state_a[`PWR_BIT_RIGHT_DAC]))
    else $error("forced right dac state not applied");

  AST_FORCED_PUMP: assert property (@(posedge clk_sys) disable iff (sys_rst)
    left_power_override_b[`PWR_BIT_CHARGE_PUMP]
    |=> pwr_up.left_b[`PWR_BIT_CHARGE_PUMP] == $past(left_power_state_b[`PWR_BIT_CHARGE_PUMP]))
    else $error("forced charge pump state not applied");

  AST_FORCED_IMP_WHOLE: assert property (@(posedge clk_sys) disable iff (sys_rst)
    left_power_override_b[`PWR_BIT_LEFT_IMP_WHOLE]
    |=> pwr_up.left_b[`PWR_BIT_LEFT_IMP_WHOLE] == $past(left_power_state_b[`PWR_BIT_LEFT_IMP_WHOLE]))
    else $error("forced whole impedance state not applied");

  AST_AUTO_LEFT_GAIN: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !left_power_override_b[`PWR_BIT_LEFT_GAIN]
    |=> pwr_up.left_b[`PWR_BIT_LEFT_GAIN] == $past(auto_pwr_up.left_b[`PWR_BIT_LEFT_GAIN]))
    else $error("left gain not on automatic control");

  // overrides for the line group arrive as a port, so this guards the wiring of that port
  AST_FORCED_LEFT_LINE: assert property (@(posedge clk_sys) disable iff (sys_rst)
    left_line_ovr[`PWR_BIT_LEFT_LINE_DRV]
    |=> pwr_up.left_a[`PWR_BIT_LEFT_LINE_DRV] == $past(left_power_state_a[`PWR_BIT_LEFT_LINE_DRV]))
    else $error("forced left line driver state not applied");

  AST_LEFT_A_RSVD_ZERO: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (left_power_state_a & ~`PWR_MASK_LEFT_STATE_A) == `PWR_READ_ZERO)
    else $error("left state a reserved bits set");

  AST_RIGHT_A_RSVD_ZERO: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (right_power_override_a & ~`PWR_MASK_RIGHT_OVR_A) == `PWR_READ_ZERO)
    else $error("right override a reserved bits set");

  AST_AUTO_RIGHT_GAIN: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !right_power_override_b[`PWR_BIT_RIGHT_GAIN]
    |=> pwr_up.right_b[`PWR_BIT_RIGHT_GAIN] == $past(auto_pwr_up.right_b[`PWR_BIT_RIGHT_GAIN]))
    else $error("right gain not on automatic control");

  AST_RIGHT_PWR_RSVD_DOWN: assert property (@(posedge clk_sys) disable iff (sys_rst)
    pwr_up.right_b[`PWR_BIT_RIGHT_RSVD] == 1'b0)
    else $error("reserved right position powered up");

  AST_READ_VALID: assert property (@(posedge clk_sys) disable iff (sys_rst)
    reg_req.re |=> reg_rvalid)
    else $error("read not answered");

  AST_READ_VALID_DROP: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !reg_req.re |=> !reg_rvalid)
    else $error("read valid without a read");

  // a register changing with no write would otherwise show only as a wrong readback much later
  AST_HOLD_WITHOUT_WRITE: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !reg_req.we
    |=> $stable(left_power_override_b) && $stable(left_power_state_a) && $stable(left_power_state_b)
        && $stable(right_power_override_a) && $stable(right_power_override_b))
    else $error("register changed without a write");

endmodule : analog_powerdown_override_bank

// >>> logic/pwr_ovr_params.svh
// constants for the analog power-down override register bank
`ifndef PWR_OVR_PARAMS_SVH
`define PWR_OVR_PARAMS_SVH

// ------------------------------------------------------------------
// register addresses
// ------------------------------------------------------------------
`define PWR_ADDR_LEFT_OVR_B 8'h23
`define PWR_ADDR_LEFT_STATE_A 8'h24
`define PWR_ADDR_LEFT_STATE_B 8'h25
`define PWR_ADDR_RIGHT_OVR_A 8'h26
`define PWR_ADDR_RIGHT_OVR_B 8'h27

// ------------------------------------------------------------------
// writable field masks and reset values
// ------------------------------------------------------------------
`define PWR_MASK_LEFT_OVR_B 8'hFF
`define PWR_MASK_LEFT_STATE_A 8'h3F
`define PWR_MASK_LEFT_STATE_B 8'hFF
`define PWR_MASK_RIGHT_OVR_A 8'h1F
`define PWR_MASK_RIGHT_OVR_B 8'hEF
`define PWR_RESET_VALUE 8'h00
`define PWR_READ_ZERO 8'h00

// ------------------------------------------------------------------
// field positions used by the logic
// ------------------------------------------------------------------
`define PWR_BIT_CHARGE_PUMP 4
`define PWR_BIT_LEFT_GAIN 7
`define PWR_BIT_RIGHT_RSVD 4
`define PWR_BIT_RIGHT_GAIN 7
`define PWR_BIT_RIGHT_DAC 4
`define PWR_BIT_LEFT_LINE_DRV 3
`define PWR_BIT_LEFT_IMP_WHOLE 0
`define PWR_MASK_LEFT_LINE 6'h3F
`define PWR_MASK_RIGHT_STATE_A 5'h1F

`endif

// >>> logic/pwr_ovr_pkg.sv
// types shared by the analog power-down override bank
package pwr_ovr_pkg;

  // register port request
  typedef struct packed {
    logic we;
    logic re;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  // one bit per analog sub-block, 1 = powered up
  typedef struct packed {
    logic [7:0] left_b;
    logic [5:0] left_a;
    logic [4:0] right_a;
    logic [7:0] right_b;
  } pwr_vec_t;

endpackage : pwr_ovr_pkg

// >>> logic/pwr_select.sv
// per-bit selection between automatic and forced power state
`timescale 1ns/1ns
module pwr_select #(
  parameter int W = 8,
  parameter logic [W-1:0] USED = '1
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [W-1:0] ovr,
  input wire logic [W-1:0] state,
  input wire logic [W-1:0] auto_up,
  output logic [W-1:0] pwr_up
);

  // ------------------------------------------------------------------
  // one flop per sub-block; reserved positions stay powered down
  // ------------------------------------------------------------------
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
        pwr_up[i] <= 1'b0;
      end else if (!USED[i]) begin
        pwr_up[i] <= 1'b0;
      end else if (ovr[i]) begin
        pwr_up[i] <= state[i];
      end else begin
        pwr_up[i] <= auto_up[i];
      end
    end
  end

endmodule : pwr_select

// >>> tb/analog_powerdown_override_bank_bench.sv
// self-checking bench for the analog power-down override bank
`timescale 1ns/1ns
module analog_powerdown_override_bank_bench;
  import pwr_ovr_pkg::*;
  // ------------------------------------------------------------------
  // stimulus signals and design
  // ------------------------------------------------------------------
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  reg_req_t reg_req = '0;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  pwr_vec_t auto_pwr_up = '0;
  logic [5:0] left_line_ovr = 6'h00;
  logic [4:0] right_state_a = 5'h00;
  logic [7:0] right_state_b = 8'h00;
  pwr_vec_t pwr_up;
  int failures = 0;
  int cmp_count = 0;
  logic [7:0] addrs [5] = '{8'h23, 8'h24, 8'h25, 8'h26, 8'h27};
  logic [7:0] masks [5] = '{8'hFF, 8'h3F, 8'hFF, 8'h1F, 8'hEF};

  initial begin
    forever #2 clk_sys = ~clk_sys;
  end

  analog_powerdown_override_bank uut (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .reg_req(reg_req),
    .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid),
    .auto_pwr_up(auto_pwr_up),
    .left_line_ovr(left_line_ovr),
    .right_state_a(right_state_a),
    .right_state_b(right_state_b),
    .pwr_up(pwr_up)
  );

  // ------------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------------
  task automatic fail(input string msg);
    $display("wrong value at %0t: %s", $time, msg);
    failures++;
  endtask : fail

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string msg);
    cmp_count++;
    if (got !== exp) fail(msg);
  endtask : chk8

  task automatic chkv(input pwr_vec_t got, input pwr_vec_t exp);
    cmp_count++;
    if (got !== exp) fail("power state vector");
  endtask : chkv

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_req <= '{we: 1'b1, re: 1'b0, addr: a, wdata: d};
    @(posedge clk_sys);
    reg_req <= '0;
  endtask : wr

  // rvalid stands one cycle only, so it is sampled just after the answering edge
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_req <= '{we: 1'b0, re: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_sys);
    reg_req <= '0;
    #1;
    chk8({7'h00, reg_rvalid}, 8'h01, "read valid");
    chk8(reg_rdata, exp, "read data");
    @(posedge clk_sys);
    #1;
    chk8({7'h00, reg_rvalid}, 8'h00, "read valid drop");
  endtask : rd

  task automatic do_reset;
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'b0;
  endtask : do_reset

  function automatic logic [7:0] sel(input logic [7:0] o, input logic [7:0] s, input logic [7:0] a);
    return (o & s) | (~o & a);
  endfunction : sel

  task automatic close_out;
    $display("counts: %0d compares, %0d mismatches", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : close_out

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_reset;
    for (int i = 0; i < 5; i++) rd(addrs[i], 8'h00);
    chkv(pwr_up, '0);
    $display("test reset values done");
  endtask : t_reset

  // reserved bits must drop ones; unmapped writes must not alias into the bank
  task automatic t_rw;
    for (int i = 0; i < 5; i++) begin
      wr(addrs[i], 8'hFF);
      rd(addrs[i], masks[i]);
      wr(addrs[i], 8'h00);
      rd(addrs[i], 8'h00);
    end
    wr(8'h22, 8'hFF);
    rd(8'h22, 8'h00);
    wr(8'h28, 8'hFF);
    rd(8'h23, 8'h00);
    $display("test register access done");
  endtask : t_rw

  task automatic t_sel;
    pwr_vec_t a;
    pwr_vec_t e;
    @(posedge clk_sys);
    left_line_ovr <= 6'h2A;
    right_state_a <= 5'h05;
    right_state_b <= 8'h5A;
    wr(8'h23, 8'hA5);
    wr(8'h24, 8'h15);
    wr(8'h25, 8'h0F);
    wr(8'h26, 8'h13);
    wr(8'h27, 8'hFF);
    for (int k = 0; k < 2; k++) begin
      a = '{left_b: 8'hC3, left_a: 6'h31, right_a: 5'h1C, right_b: 8'h96};
      if (k == 1) a = ~a;
      @(posedge clk_sys);
      auto_pwr_up <= a;
      repeat (3) @(posedge clk_sys);
      #1;
      e.left_b = sel(8'hA5, 8'h0F, a.left_b);
      e.left_a = 6'(sel(8'h2A, 8'h15, {2'b00, a.left_a}));
      e.right_a = 5'(sel(8'h13, 8'h05, {3'b000, a.right_a}));
      e.right_b = sel(8'hEF, 8'h5A, a.right_b) & 8'hEF;
      chkv(pwr_up, e);
    end
    $display("test power selection done");
  endtask : t_sel

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_reset;
    t_rw;
    t_sel;
    @(posedge clk_sys);
    auto_pwr_up <= '0;
    do_reset;
    t_reset;
    close_out;
  end

  // guards against a hang; never reached on a healthy run
  initial begin
    #100000;
    fail("run limit reached");
    close_out;
  end
endmodule : analog_powerdown_override_bank_bench
